// file: shared/wdt_defs.svh
// Register addresses, field positions, reset values and timing figures for the watchdog.
// Assumes inclusion by bare name from every file that needs them.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_ADDR_CLKCTL3 8'h41
`define WDT_ADDR_IRQEN 8'h8e
`define WDT_ADDR_WDCTL 8'he1
`define WDT_ADDR_PWRCTL1 8'h97

`define WDT_RST_CLKCTL3 8'h06
`define WDT_RST_WDCTL 8'h07
`define WDT_RST_IRQEN 8'h60

`define WDT_B_RSTEN 7
`define WDT_B_NONSTOP 6
`define WDT_B_RUN 5
`define WDT_B_CLR 4
`define WDT_B_IDLE 3
`define WDT_B_OVSRC 4
`define WDT_B_FLAG 0
`define WDT_B_FLAGIE 0
`define WDT_B_CS_HI 7
`define WDT_B_CS_LO 6
`define WDT_B_PS_HI 2

`define WDT_CS_LRC 2'h0
`define WDT_CS_EXT 2'h1
`define WDT_CS_SYS12 2'h2
`define WDT_CS_TMR 2'h3

`define WDT_SYS_DIV 4'hb

// Latency of the low-frequency path and the period below which it matters
`define WDT_LAT_US 120
`define WDT_LAT_LIMIT_MS 12

`endif

// file: shared/wdt_pkg.sv
// Types shared by the watchdog design files.
// Assumes nothing beyond the defines header.
`default_nettype none
package wdt_pkg;
	typedef enum logic [1:0]
	{
		WDT_RUN = 2'b00,
		WDT_IDLE = 2'b01,
		WDT_PDOWN = 2'b10
	} wdt_pmode_e;
endpackage
`default_nettype wire

// file: src/wdt_prescale.sv
// Watchdog prescaler: divides source ticks by 2^(sel+1).
// Assumes tick_in is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_prescale
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic tick_in,
	input wire logic [2:0] sel,
	output logic tick_out
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic out_d;
	logic [7:0] last;

	always_comb
	begin
		last = 8'hff >> (3'h7 - sel);
		cnt_d = cnt_q;
		out_d = 1'b0;
		if (clr)
		begin
			cnt_d = 8'h00;
		end
		else if (tick_in)
		begin
			if (cnt_q >= last)
			begin
				cnt_d = 8'h00;
				out_d = 1'b1;
			end
			else
			begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= 8'h00;
			tick_out <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_out <= out_d;
		end
	end
endmodule
`default_nettype wire

// file: src/wdt_top.sv
// Watchdog timer with option-fuse initialisation and write protection.
// Assumes an SFR port: addr, wdata, wr, rd, and prot_page for protected-page writes.
// Source clocks arrive as one-cycle tick pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_top
(
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic prot_page,
	input wire logic [1:0] pmode,
	input wire logic low_freq_rc_osc,
	input wire logic external_clock_in,
	input wire logic system_clock,
	input wire logic timer_overflow_clock,
	input wire logic opt_auto_enable,
	input wire logic opt_reset_enable_default,
	input wire logic opt_nonstop_default,
	input wire logic opt_idle_count_default,
	input wire logic [2:0] opt_prescale_default,
	input wire logic opt_write_protect,
	output logic [7:0] rdata,
	output logic wd_reset,
	output logic wd_irq,
	output logic wd_wake,
	output logic lrc_keep_running
);
	logic [7:0] wdctl_q;
	logic [7:0] wdctl_d;
	logic [7:0] clkctl_q;
	logic [7:0] clkctl_d;
	logic [7:0] irqen_q;
	logic [7:0] irqen_d;
	logic flag_q;
	logic flag_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [3:0] div12_q;
	logic [3:0] div12_d;
	logic sys12_tick;
	logic src_tick;
	logic ps_tick;
	logic clr_pulse;
	logic counting;
	logic ovf;
	logic lock_all;
	logic [7:0] rdata_d;
	logic rst_d;
	logic irq_d;
	logic wake_d;
	logic lrc_d;
	logic [7:0] nxt;

	// =====================================================================
	// Source selection
	always_comb
	begin
		div12_d = div12_q;
		if (system_clock)
		begin
			div12_d = (div12_q == `WDT_SYS_DIV) ? 4'h0 : div12_q + 4'h1;
		end
	end
	assign sys12_tick = system_clock && (div12_q == `WDT_SYS_DIV);

	always_comb
	begin
		case (clkctl_q[`WDT_B_CS_HI:`WDT_B_CS_LO])
			`WDT_CS_LRC: src_tick = low_freq_rc_osc;
			`WDT_CS_EXT: src_tick = external_clock_in;
			`WDT_CS_SYS12: src_tick = sys12_tick;
			default: src_tick = timer_overflow_clock;
		endcase
	end

	// =====================================================================
	// Counting conditions
	always_comb
	begin
		counting = 1'b0;
		case (pmode)
			wdt_pkg::WDT_RUN: counting = wdctl_q[`WDT_B_RUN];
			wdt_pkg::WDT_IDLE: counting = wdctl_q[`WDT_B_RUN] &&
				(wdctl_q[`WDT_B_IDLE] || opt_nonstop_default);
			wdt_pkg::WDT_PDOWN: counting = wdctl_q[`WDT_B_RUN] && wdctl_q[`WDT_B_NONSTOP] &&
				((clkctl_q[`WDT_B_CS_HI:`WDT_B_CS_LO] == `WDT_CS_LRC) ||
				(clkctl_q[`WDT_B_CS_HI:`WDT_B_CS_LO] == `WDT_CS_EXT));
			default: counting = 1'b0;
		endcase
	end

	assign clr_pulse = wr && (addr == `WDT_ADDR_WDCTL) && wdata[`WDT_B_CLR];

	// Prescale ticks; the RC latency appears as tick and pipeline delay
	wdt_prescale u_ps
	(
		.clk(clk),
		.rst(por),
		.clr(clr_pulse),
		.tick_in(src_tick && counting),
		.sel(wdctl_q[`WDT_B_PS_HI:0]),
		.tick_out(ps_tick)
	);

	// =====================================================================
	// Counter and overflow
	always_comb
	begin
		nxt = cnt_q + 8'h01;
		cnt_d = cnt_q;
		ovf = 1'b0;
		if (clr_pulse)
		begin
			cnt_d = 8'h00;
		end
		else if (ps_tick && counting)
		begin
			cnt_d = nxt;
			ovf = clkctl_q[`WDT_B_OVSRC] ? 1'b1 : (cnt_q == 8'hff);
		end
	end

	// =====================================================================
	// Register writes
	assign lock_all = opt_auto_enable && opt_write_protect;

	always_comb
	begin
		wdctl_d = wdctl_q;
		clkctl_d = clkctl_q;
		irqen_d = irqen_q;
		flag_d = flag_q;
		if (wr && (addr == `WDT_ADDR_WDCTL) && !lock_all)
		begin
			if (prot_page)
			begin
				wdctl_d[`WDT_B_RUN] = wdata[`WDT_B_RUN];
				if (!opt_write_protect)
				begin
					wdctl_d[`WDT_B_RSTEN] = wdata[`WDT_B_RSTEN];
					wdctl_d[`WDT_B_NONSTOP] = wdata[`WDT_B_NONSTOP];
				end
			end
			else
			begin
				wdctl_d[`WDT_B_RUN] = wdctl_q[`WDT_B_RUN] | wdata[`WDT_B_RUN];
				if (!opt_write_protect)
				begin
					wdctl_d[`WDT_B_RSTEN] = wdctl_q[`WDT_B_RSTEN] | wdata[`WDT_B_RSTEN];
					wdctl_d[`WDT_B_NONSTOP] = wdctl_q[`WDT_B_NONSTOP] | wdata[`WDT_B_NONSTOP];
				end
			end
			if (!opt_write_protect)
			begin
				wdctl_d[`WDT_B_IDLE] = wdata[`WDT_B_IDLE];
				wdctl_d[`WDT_B_PS_HI:0] = wdata[`WDT_B_PS_HI:0];
			end
		end
		else if (wr && (addr == `WDT_ADDR_CLKCTL3) && prot_page)
		begin
			clkctl_d = wdata;
		end
		else if (wr && (addr == `WDT_ADDR_IRQEN))
		begin
			irqen_d = wdata;
		end
		else if (wr && (addr == `WDT_ADDR_PWRCTL1) && wdata[`WDT_B_FLAG])
		begin
			flag_d = 1'b0;
		end
		wdctl_d[`WDT_B_CLR] = 1'b0;
		if (ovf)
		begin
			flag_d = 1'b1;
		end
	end

	// =====================================================================
	// Outputs
	always_comb
	begin
		rdata_d = 8'h00;
		if (rd && (addr == `WDT_ADDR_WDCTL))
		begin
			rdata_d = wdctl_q;
		end
		else if (rd && (addr == `WDT_ADDR_CLKCTL3))
		begin
			rdata_d = clkctl_q;
		end
		else if (rd && (addr == `WDT_ADDR_IRQEN))
		begin
			rdata_d = irqen_q;
		end
		else if (rd && (addr == `WDT_ADDR_PWRCTL1))
		begin
			rdata_d = {7'h00, flag_q};
		end
		rst_d = ovf && wdctl_q[`WDT_B_RSTEN];
		irq_d = flag_d && irqen_q[`WDT_B_FLAGIE];
		wake_d = (pmode == wdt_pkg::WDT_PDOWN) && ovf &&
			(wdctl_q[`WDT_B_RSTEN] || irqen_q[`WDT_B_FLAGIE]);
		lrc_d = wdctl_q[`WDT_B_RUN] && wdctl_q[`WDT_B_NONSTOP];
	end

	// Control state cleared only by power-on; pin, software and watchdog resets skip it
	always_ff @(posedge clk)
	begin
		if (por)
		begin
			if (opt_auto_enable)
			begin
				wdctl_q <= {opt_reset_enable_default, opt_nonstop_default, 1'b1, 1'b0,
					opt_idle_count_default, opt_prescale_default};
			end
			else
			begin
				wdctl_q <= `WDT_RST_WDCTL;
			end
			clkctl_q <= `WDT_RST_CLKCTL3;
		end
		else
		begin
			wdctl_q <= wdctl_d;
			clkctl_q <= clkctl_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || por)
		begin
			irqen_q <= `WDT_RST_IRQEN;
			flag_q <= 1'b0;
			cnt_q <= 8'h00;
			div12_q <= 4'h0;
			rdata <= 8'h00;
			wd_reset <= 1'b0;
			wd_irq <= 1'b0;
			wd_wake <= 1'b0;
			lrc_keep_running <= 1'b0;
		end
		else
		begin
			irqen_q <= irqen_d;
			flag_q <= flag_d;
			cnt_q <= cnt_d;
			div12_q <= div12_d;
			rdata <= rdata_d;
			wd_reset <= rst_d;
			wd_irq <= irq_d;
			wd_wake <= wake_d;
			lrc_keep_running <= lrc_d;
		end
	end
endmodule
`default_nettype wire

// file: tb/wdt_top_chk.sv
// Port-level assertions for the watchdog top.
// Assumes a bind onto wdt_top; ports match by name.
`timescale 1ns/1ps
`default_nettype none
module wdt_top_chk
(
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [1:0] pmode,
	input wire logic [7:0] rdata,
	input wire logic wd_reset,
	input wire logic wd_irq,
	input wire logic wd_wake,
	input wire logic lrc_keep_running
);
	// ====
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || por);
	chk_reset_pulse: assert property (wd_reset |=> !wd_reset)
		else $error("reset pulse too long");
	chk_wake_pulse: assert property (wd_wake |=> !wd_wake)
		else $error("wake pulse too long");
	chk_wake_pdown: assert property (wd_wake |-> $past(pmode) == 2'h2)
		else $error("wake outside power-down");
	chk_wake_nonstop: assert property (wd_wake |-> lrc_keep_running)
		else $error("wake without nonstop");
	chk_irq_mask: assert property (wr && addr == 8'h8e && !wdata[0] |-> ##[1:2] !wd_irq)
		else $error("irq not masked");
	chk_irq_hold: assert property (wd_irq && !wr && !$past(wr) |=> wd_irq)
		else $error("irq dropped alone");
	chk_clr_reads0: assert property (rd && addr == 8'he1 |=> !rdata[4])
		else $error("clear bit reads one");
	chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("rdata without read");
endmodule
bind wdt_top wdt_top_chk u_chk
(
	.clk(clk),
	.rst(rst),
	.por(por),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.pmode(pmode),
	.rdata(rdata),
	.wd_reset(wd_reset),
	.wd_irq(wd_irq),
	.wd_wake(wd_wake),
	.lrc_keep_running(lrc_keep_running)
);
`default_nettype wire

// file: tb/wdt_top_bench.sv
// Self-checking bench for the watchdog top.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module wdt_top_bench;
	logic clk = 0, rst = 1, por = 1, wr = 0, rd = 0, prot_page = 0;
	logic low_freq_rc_osc = 0, external_clock_in = 0, system_clock = 0, timer_overflow_clock = 0;
	logic opt_auto_enable = 0, opt_reset_enable_default = 0, opt_nonstop_default = 0;
	logic opt_idle_count_default = 0, opt_write_protect = 0;
	logic [2:0] opt_prescale_default = 3'h0;
	logic [1:0] pmode = 2'h0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic wd_reset, wd_irq, wd_wake, lrc_keep_running;
	int failures = 0, tests_run = 0, nr, ni, nw;
	wdt_top DUT (.*);
	always #2.5 clk = ~clk;
	// ====
	// Tasks
	task automatic chk(input logic [15:0] g, e);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [7:0] a, d, input logic p);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		prot_page <= p;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic r(input logic [7:0] a, e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, e);
	endtask
	task automatic tk(input logic [3:0] t);
		@(posedge clk);
		{timer_overflow_clock, system_clock, external_clock_in, low_freq_rc_osc} <= t;
	endtask
	task automatic obs(input int n);
		nr = 0;
		ni = 0;
		nw = 0;
		repeat (n)
		begin
			@(negedge clk);
			nr += (wd_reset === 1'b1);
			ni += (wd_irq === 1'b1);
			nw += (wd_wake === 1'b1);
		end
	endtask
	task automatic pwr(input logic [7:0] o);
		@(posedge clk);
		por <= 1;
		{opt_auto_enable, opt_write_protect, opt_reset_enable_default, opt_nonstop_default,
			opt_idle_count_default, opt_prescale_default} <= o;
		repeat (3) @(posedge clk);
		por <= 0;
		rst <= 0;
	endtask
	task automatic per(input logic [15:0] e);
		int c;
		c = 0;
		repeat (2)
		begin
			@(negedge clk);
			while (wd_reset !== 1'b1 && c < 1200)
			begin
				c++;
				@(negedge clk);
			end
		end
		c = 1;
		@(negedge clk);
		while (wd_reset !== 1'b1 && c < 600)
		begin
			c++;
			@(negedge clk);
		end
		chk(16'(c), e);
	endtask
	task automatic pm(input logic [1:0] m, cs, input logic [7:0] c, input logic e);
		tk(0);
		w(8'h41, {cs, 6'h16}, 1);
		w(8'h97, 8'h01, 0);
		w(8'he1, c, 1);
		pmode <= m;
		tk(4'h1 << cs);
		obs(40);
		chk(16'(lrc_keep_running), 16'(c[6]));
		tk(0);
		pmode <= 0;
		chk(16'(ni > 0), 16'(e));
		chk(16'(nw > 0), 16'(e && m == 2'h2));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ====
	// Scenarios
	initial
	begin
		pwr(8'h00);
		r(8'he1, 8'h07);
		r(8'h41, 8'h06);
		r(8'h8e, 8'h60);
		w(8'h41, 8'h10, 0);
		r(8'h41, 8'h06);
		w(8'h41, 8'h16, 1);
		w(8'he1, 8'ha0, 0);
		r(8'he1, 8'ha0);
		tk(4'h1);
		for (int i = 0; i < 8; i++)
		begin
			w(8'he1, {5'h14, 3'(i)}, 1);
			per(16'h2 << i);
		end
		w(8'h41, 8'h06, 1);
		w(8'he1, 8'ha0, 1);
		per(16'h200);
		w(8'he1, 8'h00, 0);
		r(8'he1, 8'ha0);
		w(8'he1, 8'h20, 1);
		r(8'he1, 8'h20);
		w(8'h41, 8'h16, 1);
		w(8'h8e, 8'h61, 0);
		obs(20);
		chk(16'(nr), 0);
		chk(16'(ni > 10), 1);
		w(8'h8e, 8'h60, 0);
		obs(2);
		obs(10);
		chk(16'(ni), 0);
		tk(0);
		w(8'h97, 8'h00, 0);
		r(8'h97, 8'h01);
		w(8'h97, 8'h01, 0);
		r(8'h97, 8'h00);
		w(8'h41, 8'h06, 1);
		tk(4'h1);
		w(8'he1, 8'h30, 0);
		w(8'h97, 8'h01, 0);
		repeat (6)
		begin
			obs(100);
			w(8'he1, 8'h30, 0);
		end
		r(8'h97, 8'h00);
		obs(600);
		r(8'h97, 8'h01);
		w(8'h8e, 8'h61, 0);
		pm(2'h1, 2'h0, 8'h20, 0);
		pm(2'h1, 2'h0, 8'h28, 1);
		pm(2'h2, 2'h0, 8'h20, 0);
		pm(2'h2, 2'h0, 8'h60, 1);
		pm(2'h2, 2'h1, 8'h60, 1);
		pm(2'h2, 2'h2, 8'h60, 0);
		pm(2'h0, 2'h2, 8'h20, 1);
		pm(2'h0, 2'h3, 8'h20, 1);
		pwr(8'had);
		r(8'he1, 8'had);
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		r(8'he1, 8'had);
		pwr(8'hed);
		w(8'he1, 8'h00, 1);
		r(8'he1, 8'had);
		w(8'h41, 8'h16, 1);
		tk(4'h1);
		repeat (4)
		begin
			w(8'he1, 8'h10, 1);
			obs(40);
			chk(16'(nr), 0);
		end
		obs(80);
		chk(16'(nr > 0), 1);
		tk(0);
		pwr(8'h40);
		w(8'he1, 8'hff, 0);
		r(8'he1, 8'h27);
		w(8'he1, 8'h00, 1);
		r(8'he1, 8'h07);
		pwr(8'h90);
		w(8'h8e, 8'h61, 0);
		pm(2'h1, 2'h0, 8'h20, 1);
		tally_and_finish();
	end
	initial
	begin
		#200000;
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
